// ### src/sied_bank.sv
// Edge-select bank for switch inputs 18 to 21: config register, crossing detection, status readback.
// Assumes register requests arrive as single-cycle strobes from the serial front end,
// and comparator levels for all four inputs come with one common sample strobe.
//
// Contract
// - 24-bit read-write edge-select register at 27h, resets to zero.
// - Bits 23 to 18 select edges for switch input 21.
// - Bits 17 to 12 select edges for switch input 20.
// - Bits 11 to 6 select edges for switch input 19.
// - Bits 5 to 0 select edges for switch input 18.
// - Field bits 1:0 act on the first threshold; 00 means no interrupt.
// - Slot value 01 raises an interrupt on a rising crossing.
// - Slot value 10 raises an interrupt on a falling crossing.
// - Slot value 11 raises an interrupt on either crossing.
// - Field bits 3:2 apply the same encoding to the second threshold.
// - Field bits 5:4 apply the same encoding to the third threshold.
`include "sied_cfg.svh"

module sied_bank (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire sied_pkg::sied_regreq_t regReq,
    output logic [`SIED_DATA_W-1:0] regRdData,
    output logic regRdValid,
    input wire logic sampleValid,
    input wire sied_pkg::sied_levels_t switchInput18,
    input wire sied_pkg::sied_levels_t switchInput19,
    input wire sied_pkg::sied_levels_t switchInput20,
    input wire sied_pkg::sied_levels_t switchInput21,
    output logic [`SIED_NUM_INPUTS-1:0] irqRequest
);
    import sied_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Used for both the write strobe and the read mux
    function automatic logic addr_is(input logic [`SIED_ADDR_W-1:0] a, input logic [`SIED_ADDR_W-1:0] ref_a);
        return a == ref_a;
    endfunction

    logic edgeSelWrite;
    logic crossStatRead;

    always_comb begin
        edgeSelWrite = regReq.write && addr_is(regReq.addr, `SIED_EDGE_SEL_ADDR);
        crossStatRead = regReq.read && addr_is(regReq.addr, `SIED_CROSS_STAT_ADDR);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge-select register

    logic [`SIED_DATA_W-1:0] switchIrqEdgeSelIn18to21;

    sied_cfg_reg i_sied_cfg_reg (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .writeEn(edgeSelWrite),
        .writeData(regReq.wdata),
        .value(switchIrqEdgeSelIn18to21)
    );

    sied_field_t input18EdgeSelect;
    sied_field_t input19EdgeSelect;
    sied_field_t input20EdgeSelect;
    sied_field_t input21EdgeSelect;

    always_comb begin
        input18EdgeSelect = switchIrqEdgeSelIn18to21[`SIED_SWITCH_INPUT_18_LSB +: `SIED_FIELD_W];
        input19EdgeSelect = switchIrqEdgeSelIn18to21[`SIED_SWITCH_INPUT_19_LSB +: `SIED_FIELD_W];
        input20EdgeSelect = switchIrqEdgeSelIn18to21[`SIED_SWITCH_INPUT_20_LSB +: `SIED_FIELD_W];
        input21EdgeSelect = switchIrqEdgeSelIn18to21[`SIED_SWITCH_INPUT_21_LSB +: `SIED_FIELD_W];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-input crossing detection

    sied_levels_t levelsArr [`SIED_NUM_INPUTS];
    sied_field_t selectArr [`SIED_NUM_INPUTS];
    logic [`SIED_NUM_SLOTS-1:0] riseArr [`SIED_NUM_INPUTS];
    logic [`SIED_NUM_SLOTS-1:0] fallArr [`SIED_NUM_INPUTS];
    logic [`SIED_NUM_INPUTS-1:0] hitVec;

    always_comb begin
        levelsArr[0] = switchInput18;
        levelsArr[1] = switchInput19;
        levelsArr[2] = switchInput20;
        levelsArr[3] = switchInput21;
        selectArr[0] = input18EdgeSelect;
        selectArr[1] = input19EdgeSelect;
        selectArr[2] = input20EdgeSelect;
        selectArr[3] = input21EdgeSelect;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `SIED_NUM_INPUTS; gi++) begin : g_in
            sied_edge_detect i_sied_edge_detect (
                .mclk(mclk),
                .resetn(resetn),
                .ce(ce),
                .sampleValid(sampleValid),
                .levels(levelsArr[gi]),
                .select(selectArr[gi]),
                .rise(riseArr[gi]),
                .fall(fallArr[gi]),
                .hit(hitVec[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt requests
    // One-cycle pulse per input, one clock after the sample that crossed.
    // Status latching and the pin live downstream; this bank only qualifies events.

    logic [`SIED_NUM_INPUTS-1:0] next_irqRequest;

    always_comb begin
        next_irqRequest = hitVec;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irqRequest <= '0;
        end else if (ce) begin
            irqRequest <= next_irqRequest;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing status
    // Sticky record of every crossing seen, enabled or not, so software can
    // tune thresholds before arming them. Cleared by reading it; a crossing
    // landing in the clearing cycle survives the clear.

    logic [`SIED_DATA_W-1:0] crossStat;
    logic [`SIED_DATA_W-1:0] next_crossStat;
    logic [`SIED_DATA_W-1:0] crossNow;

    generate
        // One driver per slice; several always_comb blocks on one vector are refused
        for (gi = 0; gi < `SIED_NUM_INPUTS; gi++) begin : g_stat
            assign crossNow[gi*`SIED_STAT_W +: `SIED_STAT_W] = {fallArr[gi], riseArr[gi]};
        end
    endgenerate

    always_comb begin
        next_crossStat = crossStat;
        if (crossStatRead) begin
            next_crossStat = `SIED_ZERO_DATA;
        end
        next_crossStat = next_crossStat | crossNow;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            crossStat <= `SIED_ZERO_DATA;
        end else if (ce) begin
            crossStat <= next_crossStat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level snapshot, taken on each sample strobe

    logic [`SIED_NUM_INPUTS*`SIED_LEVEL_W-1:0] levelSnap;
    logic [`SIED_NUM_INPUTS*`SIED_LEVEL_W-1:0] next_levelSnap;

    always_comb begin
        next_levelSnap = levelSnap;
        if (sampleValid) begin
            next_levelSnap = {switchInput21, switchInput20, switchInput19, switchInput18};
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            levelSnap <= '0;
        end else if (ce) begin
            levelSnap <= next_levelSnap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    // Data registered, one clock after the read strobe. Unmapped addresses read zero.

    logic [`SIED_DATA_W-1:0] next_regRdData;
    logic next_regRdValid;

    always_comb begin
        next_regRdData = regRdData;
        next_regRdValid = regReq.read;
        if (regReq.read) begin
            if (addr_is(regReq.addr, `SIED_EDGE_SEL_ADDR)) begin
                next_regRdData = switchIrqEdgeSelIn18to21;
            end else if (addr_is(regReq.addr, `SIED_CROSS_STAT_ADDR)) begin
                next_regRdData = crossStat;
            end else if (addr_is(regReq.addr, `SIED_LEVEL_STAT_ADDR)) begin
                next_regRdData = {{(`SIED_DATA_W-`SIED_NUM_INPUTS*`SIED_LEVEL_W){1'b0}}, levelSnap};
            end else begin
                next_regRdData = `SIED_ZERO_DATA;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= `SIED_ZERO_DATA;
            regRdValid <= 1'b0;
        end else if (ce) begin
            regRdData <= next_regRdData;
            regRdValid <= next_regRdValid;
        end
    end
endmodule

// ### src/sied_cfg.svh
// Constants of the switch edge-select bank: offsets, field positions, reset values, encodings.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SIED_CFG_SVH
`define SIED_CFG_SVH

// Register port
`define SIED_ADDR_W 6
`define SIED_DATA_W 24
`define SIED_EDGE_SEL_ADDR 6'h27
`define SIED_CROSS_STAT_ADDR 6'h3A
`define SIED_LEVEL_STAT_ADDR 6'h3B
`define SIED_EDGE_SEL_RESET 24'h00_0000
`define SIED_ZERO_DATA 24'h00_0000

// Inputs and slots
`define SIED_NUM_INPUTS 4
`define SIED_NUM_SLOTS 3
`define SIED_FIELD_W 6
`define SIED_SWITCH_INPUT_18_LSB 0
`define SIED_SWITCH_INPUT_19_LSB 6
`define SIED_SWITCH_INPUT_20_LSB 12
`define SIED_SWITCH_INPUT_21_LSB 18

// Two-bit slot encoding
`define SIED_SEL_NONE 2'h0
`define SIED_SEL_RISE 2'h1
`define SIED_SEL_FALL 2'h2
`define SIED_SEL_BOTH 2'h3

// Crossing status: six bits per input, rising flags low, falling flags high
`define SIED_STAT_W 6
`define SIED_LEVEL_W 3

`endif

// ### src/sied_pkg.sv
// Types shared by the switch edge-select bank.
// Assumes sied_cfg.svh on the include path.
`include "sied_cfg.svh"

package sied_pkg;

    // One input's edge-select field; third threshold slot sits highest
    typedef struct packed {
        logic [1:0] third;
        logic [1:0] second;
        logic [1:0] first;
    } sied_field_t;

    // Comparator results of one input: one means above the threshold
    typedef struct packed {
        logic third;
        logic second;
        logic first;
    } sied_levels_t;

    // Register access request from the serial front end
    typedef struct packed {
        logic write;
        logic read;
        logic [`SIED_ADDR_W-1:0] addr;
        logic [`SIED_DATA_W-1:0] wdata;
    } sied_regreq_t;

    typedef enum logic {
        SIED_UNPRIMED,
        SIED_ARMED
    } sied_prime_t;

endpackage

// ### src/sied_cfg_reg.sv
// Storage for the 24-bit edge-select register.
// Assumes the caller has already decoded the address into a write strobe.
`include "sied_cfg.svh"

module sied_cfg_reg (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic writeEn,
    input wire logic [`SIED_DATA_W-1:0] writeData,
    output logic [`SIED_DATA_W-1:0] value
);
    import sied_pkg::*;

    logic [`SIED_DATA_W-1:0] next_value;

    always_comb begin
        next_value = value;
        if (writeEn) begin
            next_value = writeData;
        end
    end

    // Nothing is enabled out of reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            value <= `SIED_EDGE_SEL_RESET;
        end else if (ce) begin
            value <= next_value;
        end
    end
endmodule

// ### src/sied_edge_detect.sv
// Crossing detector for one switch input against its three thresholds.
// Assumes levels are valid whenever sampleValid is high.
`include "sied_cfg.svh"

module sied_edge_detect (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic sampleValid,
    input wire sied_pkg::sied_levels_t levels,
    input wire sied_pkg::sied_field_t select,
    output logic [`SIED_NUM_SLOTS-1:0] rise,
    output logic [`SIED_NUM_SLOTS-1:0] fall,
    output logic hit
);
    import sied_pkg::*;

    sied_levels_t prev;
    sied_levels_t next_prev;
    sied_prime_t state;
    sied_prime_t next_state;
    logic [`SIED_NUM_SLOTS-1:0] slotHit;

    // A slot fires for its selected direction only
    function automatic logic slot_fires(input logic [1:0] sel, input logic up, input logic down);
        logic res;
        res = 1'b0;
        case (sel)
            `SIED_SEL_NONE: res = 1'b0;
            `SIED_SEL_RISE: res = up;
            `SIED_SEL_FALL: res = down;
            `SIED_SEL_BOTH: res = up | down;
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    always_comb begin
        next_prev = prev;
        next_state = state;
        // The first sample after reset has no predecessor, so it only primes
        if (sampleValid) begin
            next_prev = levels;
            case (state)
                SIED_UNPRIMED: next_state = SIED_ARMED;
                SIED_ARMED: next_state = SIED_ARMED;
                default: next_state = SIED_UNPRIMED;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prev <= '0;
            state <= SIED_UNPRIMED;
        end else if (ce) begin
            prev <= next_prev;
            state <= next_state;
        end
    end

    always_comb begin
        rise = '0;
        fall = '0;
        if (sampleValid && state == SIED_ARMED) begin
            rise = levels & ~prev;
            fall = ~levels & prev;
        end
        slotHit[0] = slot_fires(select.first, rise[0], fall[0]);
        slotHit[1] = slot_fires(select.second, rise[1], fall[1]);
        slotHit[2] = slot_fires(select.third, rise[2], fall[2]);
        hit = |slotHit;
    end
endmodule

// ### testbench/sied_bank_props.sv
// Port checker for the switch edge-select bank.
// Assumes one clock domain and binding onto sied_bank.
`include "sied_cfg.svh"
module sied_bank_props (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire sied_pkg::sied_regreq_t regReq,
    input wire logic [`SIED_DATA_W-1:0] regRdData,
    input wire logic regRdValid,
    input wire logic sampleValid,
    input wire sied_pkg::sied_levels_t switchInput18,
    input wire sied_pkg::sied_levels_t switchInput19,
    input wire sied_pkg::sied_levels_t switchInput20,
    input wire sied_pkg::sied_levels_t switchInput21,
    input wire logic [`SIED_NUM_INPUTS-1:0] irqRequest
);
    timeunit 1ns;
    timeprecision 100ps;
    import sied_pkg::*;
    ////////////////////////////////////////
    logic [23:0] cfg;
    logic [11:0] prev;
    logic primed;
    logic [11:0] cur;
    logic [3:0] expIrq;
    function automatic logic [3:0] hits(logic [23:0] c, logic [11:0] p, logic [11:0] n);
        hits = 4'h0;
        for (int i = 0; i < 12; i++)
            hits[i/3] |= (c[2*i] & ~p[i] & n[i]) | (c[2*i+1] & p[i] & ~n[i]);
    endfunction
    assign cur = {switchInput21, switchInput20, switchInput19, switchInput18};
    // Unprimed detectors must stay silent on the first sample
    assign expIrq = primed ? hits(cfg, prev, cur) : 4'h0;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg <= `SIED_ZERO_DATA;
            prev <= 12'h000;
            primed <= 1'b0;
        end else if (ce) begin
            if (regReq.write && regReq.addr == `SIED_EDGE_SEL_ADDR)
                cfg <= regReq.wdata;
            if (sampleValid) begin
                prev <= cur;
                primed <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    a_rd_valid_lat: assert property (ce && regReq.read |=> regRdValid) else $error("read valid missing");
    // Guarded by ce so a frozen valid is not taken for a spurious one
    a_rd_valid_cause: assert property (regRdValid && $past(ce) |-> $past(ce && regReq.read))
        else $error("read valid without read");
    a_rd_data_match: assert property (ce && regReq.read && regReq.addr == `SIED_EDGE_SEL_ADDR
        |=> regRdData == $past(cfg)) else $error("edge select readback wrong");
    a_rd_unmapped_zero: assert property (ce && regReq.read && !(regReq.addr inside {6'h27, 6'h3A, 6'h3B})
        |=> regRdData == `SIED_ZERO_DATA) else $error("unmapped read not zero");
    a_irq_exact: assert property (ce && sampleValid |=> irqRequest == $past(expIrq))
        else $error("interrupt pattern wrong");
    a_irq_quiet: assert property (ce && !sampleValid |=> irqRequest == 4'h0) else $error("irq without sample");
    a_irq_enable21: assert property (irqRequest[3] && $past(ce) |-> $past(cfg[23:18]) != 6'h00)
        else $error("input 21 irq while disabled");
    a_ce_freeze: assert property (!ce |=> $stable(irqRequest) && $stable(regRdValid) && $stable(regRdData))
        else $error("outputs moved with ce low");
    c_read: cover property (ce && regReq.read && regReq.addr == `SIED_EDGE_SEL_ADDR);
    c_irq: cover property (ce && sampleValid && expIrq == 4'hF);
    c_freeze: cover property (!ce && sampleValid);
endmodule

bind sied_bank sied_bank_props i_sied_bank_props (.mclk(mclk), .resetn(resetn), .ce(ce), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .sampleValid(sampleValid), .switchInput18(switchInput18),
    .switchInput19(switchInput19), .switchInput20(switchInput20), .switchInput21(switchInput21),
    .irqRequest(irqRequest));

// ### testbench/sied_host.sv
// Host model issuing register strobes to the bank.
// Assumes ce is high during every transfer.
`include "sied_cfg.svh"
module sied_host (
    input wire logic mclk,
    output sied_pkg::sied_regreq_t regReq,
    input wire logic [`SIED_DATA_W-1:0] regRdData,
    input wire logic regRdValid
);
    timeunit 1ns;
    timeprecision 100ps;
    import sied_pkg::*;
    ////////////////////////////////////////
    initial regReq = 32'h0000_0000;
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [23:0] d, output logic [23:0] rd);
        @(posedge mclk);
        #1;
        regReq = {wr, ~wr, a, d};
        @(posedge mclk);
        #1;
        // Released address and data are inverted so stale values never look valid
        regReq = {2'b00, ~a, ~d};
        rd = (wr || regRdValid === 1'b1) ? regRdData : 24'hxx_xxxx;
    endtask
endmodule

// ### testbench/tb_sied_bank.sv
// Self-checking bench for the switch edge-select bank.
// Assumes the host model and the bound checker are compiled alongside.
`include "sied_cfg.svh"
module tb_sied_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import sied_pkg::*;
    logic mclk, resetn, ce, sampleValid, primed, regRdValid;
    logic [11:0] lv, prev;
    logic [23:0] cfg, rd, regRdData;
    logic [3:0] irqRequest;
    sied_regreq_t regReq;
    int err_count = 0;
    int n_checks = 0;
    sied_bank i_sied_bank (.mclk(mclk), .resetn(resetn), .ce(ce), .regReq(regReq), .regRdData(regRdData),
        .regRdValid(regRdValid), .sampleValid(sampleValid), .switchInput18(lv[2:0]), .switchInput19(lv[5:3]),
        .switchInput20(lv[8:6]), .switchInput21(lv[11:9]), .irqRequest(irqRequest));
    sied_host i_sied_host (.mclk(mclk), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////
    function automatic logic [3:0] hits(logic [23:0] c, logic [11:0] p, logic [11:0] n);
        hits = 4'h0;
        for (int i = 0; i < 12; i++)
            hits[i/3] |= (c[2*i] & ~p[i] & n[i]) | (c[2*i+1] & p[i] & ~n[i]);
    endfunction
    task automatic chk_data(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected data at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected irq at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        i_sied_host.xfer(1'b1, a, d, rd);
        if (a == 6'h27)
            cfg = d;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [23:0] exp);
        i_sied_host.xfer(1'b0, a, 24'h00_0000, rd);
        chk_data(rd, exp);
    endtask
    task automatic samp(input logic [11:0] v);
        logic [3:0] e;
        @(posedge mclk);
        #1;
        lv = v;
        sampleValid = 1'b1;
        e = (primed && ce) ? hits(cfg, prev, v) : 4'h0;
        if (ce) begin
            prev = v;
            primed = 1'b1;
        end
        @(posedge mclk);
        #1;
        sampleValid = 1'b0;
        lv = ~v;
        chk_irq(irqRequest, e);
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        resetn = 1'b1;
        cfg = 24'h00_0000;
        prev = 12'h000;
        primed = 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
    initial begin
        {resetn, ce, sampleValid, lv} = {3'b010, 12'h000};
        void'($urandom(32'h325f_3345));
        do_reset();
        rdchk(6'h27, 24'h00_0000);
        for (int i = 0; i < 4; i++) begin
            wr(6'h27, 24'h00_003F << (6 * i));
            rdchk(6'h27, 24'h00_003F << (6 * i));
        end
        wr(6'h3A, 24'h00_0FFF);
        rdchk(6'h27, 24'hFC_0000);
        rdchk(6'h10, 24'h00_0000);
        $display("test registers done");
        for (int s = 0; s < 3; s++)
            for (int c = 0; c < 4; c++) begin
                wr(6'h27, {4{6'(c << (2 * s))}});
                samp(12'h000);
                samp({4{3'(1 << s)}});
                samp(12'h000);
            end
        $display("test codes done");
        repeat (300) begin
            if ($urandom_range(0, 7) == 0)
                wr(6'h27, 24'($urandom));
            samp(12'($urandom));
        end
        $display("test random done");
        wr(6'h27, 24'hFF_FFFF);
        samp(12'h000);
        @(posedge mclk);
        #1;
        ce = 1'b0;
        samp(12'hFFF);
        ce = 1'b1;
        samp(12'hFFF);
        $display("test enable done");
        do_reset();
        rdchk(6'h27, 24'h00_0000);
        wr(6'h27, 24'hFF_FFFF);
        samp(12'hFFF);
        rdchk(6'h3B, 24'h00_0FFF);
        rdchk(6'h3A, 24'h00_0000);
        samp(12'h000);
        rdchk(6'h3A, 24'hE3_8E38);
        rdchk(6'h3A, 24'h00_0000);
        rdchk(6'h3B, 24'h00_0000);
        $display("test reset done");
        stop_test();
    end
endmodule
